// ---- rtl/vdc_pkg.sv ----
// Constants and types shared by the radio discrete control logic
package vdc_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] FREQ_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] SETUP_ADDR = 8'h0c;
   // Control register fields
   localparam int CTRL_NARROW_BIT = 0;
   localparam int CTRL_SIDETONE_BIT = 1;
   localparam int CTRL_SQUELCH_BIT = 2;
   localparam int CTRL_WARN_BIT = 3;
   localparam int CTRL_FAIL_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h04;
   // Status register fields
   localparam int ST_TX_BIT = 0;
   localparam int ST_STUCK_BIT = 1;
   localparam int ST_EMERGENCY_REQUEST_BIT = 2;
   localparam int ST_POWER_BIT = 3;
   localparam int ST_STATION_BIT = 4;
   localparam int ST_RS422_BIT = 5;
   localparam int ST_DESENSE_BIT = 6;
   localparam int ST_SETUP_BIT = 7;
   localparam int ST_PERMIT_BIT = 8;
   localparam int ST_OVERTEMP_BIT = 9;
   localparam int ST_VSWR_BIT = 10;
   localparam int ST_REJECT_BIT = 11;
   localparam int ST_STUCK_EV_BIT = 12;
   localparam logic [15:0] SETUP_RESET = 16'h0000;
   // Discrete input vector positions
   localparam int IN_POWER = 0;
   localparam int IN_PTT = 1;
   localparam int IN_STATION = 2;
   localparam int IN_PORT = 3;
   localparam int IN_DESENSE = 4;
   localparam int IN_SETUP = 5;
   localparam int IN_PERMIT = 6;
   localparam int IN_EMERGENCY_REQUEST = 7;
   localparam int IN_OVERTEMP = 8;
   localparam int IN_VSWR = 9;
   localparam int IN_AUDIO = 10;
   localparam int IN_COUNT = 11;
   // Idle levels: active-low pins rest high, monitor inputs rest low
   localparam logic [10:0] IN_IDLE = 11'h0ff;
   // Tuning, in kHz
   localparam logic [17:0] BAND_LOW_KHZ = 18'h1ccf0;
   localparam logic [17:0] BAND_HIGH_KHZ = 18'h2170f;
   localparam logic [17:0] BAND_EXT_KHZ = 18'h26147;
   localparam logic [17:0] EMERGENCY_REQUEST_KHZ = 18'h1da9c;
   localparam logic [17:0] FREQ_RESET = 18'h1ccf0;
   // Timing
   localparam longint unsigned CLK_HZ = 125000000;
   localparam longint unsigned STUCK_S = 30;
   localparam longint unsigned STUCK_CYC = STUCK_S * CLK_HZ;
   localparam longint unsigned DEB_US = 10;
   localparam longint unsigned DEB_CYC = DEB_US * CLK_HZ / 1000000;
   localparam logic [10:0] DEB_LAST = 11'(DEB_CYC - 1);

   typedef struct packed {
      logic narrow;
      logic [17:0] freq_khz;
   } vdc_tune_type;

   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } vdc_led_type;
endpackage : vdc_pkg

// ---- rtl/vdc_top.sv ----
// Discrete control and status logic of a remote VHF-AM transceiver
//
// Behaviour
// - Power request low powers unit up
// - Push-to-talk low starts transmit if permitted
// - Transmit ends after thirty seconds stuck key
// - Transmitting state readable by the controller
// - Station select low picks second identity
// - Port select low uses RS422, else ARINC
// - Desense low reduces receiver gain
// - Setup data accessible only with access low
// - Transmit permit high blocks all transmission
// - Emergency variant enters emergency on request
// - Emergency tunes 121.5 MHz, wide spacing
// - Emergency ignores tuning, keeps status
// - Wide and narrow channel spacing supported
// - Tuning accepted only inside band limits
// - Green operable, yellow warning, red failure
// - Fault output active when yellow or red
// - Monitor temperature and VSWR, overheat holds transmitter off
// - Audio indicator inactive in transmit or muted
// - Audio indicator active when audio passes
// - Sidetone routed while transmitting if enabled
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module vdc_top #(
   parameter logic [31:0] STUCK_CYCLES = 32'(vdc_pkg::STUCK_CYC),
   parameter bit EMERGENCY_REQUEST_VARIANT = 1'b1,
   parameter bit EXT_BAND = 1'b0
) (
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic PWR_REQ_B_I,
   input wire logic PUSH_TO_TALK_B_I,
   input wire logic STATION_SELECT_B_I,
   input wire logic SERIAL_PORT_SELECT_B_I,
   input wire logic RECEIVER_DESENSE_B_I,
   input wire logic SETUP_ACCESS_ENABLE_B_I,
   input wire logic TX_PERMIT_B_I,
   input wire logic EMERGENCY_REQUEST_B_I,
   input wire logic OVERTEMP_I,
   input wire logic VSWR_HIGH_I,
   input wire logic RX_AUDIO_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic POWER_EN_O,
   output logic TX_KEY_O,
   output logic SIDETONE_O,
   output logic RX_DESENSE_O,
   output logic STATION_SECOND_O,
   output logic USE_RS422_O,
   output vdc_pkg::vdc_tune_type TUNE_O,
   output vdc_pkg::vdc_led_type LED_O,
   output logic FAULT_O,
   output logic FAULT_OE_O,
   output logic AUDIO_PRESENT_O,
   output logic AUDIO_PRESENT_OE_O
);
   logic [10:0] pins;
   logic [10:0] sync1_q;
   logic [10:0] sync2_q;
   logic [10:0] deb_q;
   logic pwr;
   logic ptt;
   logic permit;
   logic setup_en;
   logic emergency_request_act;
   logic overtemp;
   logic vswr;
   logic [31:0] stuck_cnt_q;
   logic stuck_q;
   logic stuck_hit;
   logic tx_d;
   logic tx_q;
   logic emergency_request_q;
   logic [4:0] ctrl_q;
   logic [15:0] setup_q;
   logic reject_q;
   logic stuck_ev_q;
   logic wr_freq;
   logic freq_ok;
   logic [17:0] band_high;
   logic [31:0] status;
   logic [31:0] rd_d;
   logic yellow_d;
   logic red_d;
   logic audio_d;
   vdc_pkg::vdc_tune_type tune_q;

   assign pins = {RX_AUDIO_I, VSWR_HIGH_I, OVERTEMP_I,
                  EMERGENCY_REQUEST_B_I, TX_PERMIT_B_I,
                  SETUP_ACCESS_ENABLE_B_I, RECEIVER_DESENSE_B_I,
                  SERIAL_PORT_SELECT_B_I, STATION_SELECT_B_I,
                  PUSH_TO_TALK_B_I, PWR_REQ_B_I};

   // Two-flop synchroniser, then a hold-time filter per pin
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sync1_q <= vdc_pkg::IN_IDLE;
         sync2_q <= vdc_pkg::IN_IDLE;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < vdc_pkg::IN_COUNT; gi++) begin : g_deb
         logic [10:0] cnt_q;
         // Relay-driven lines bounce; accept a level only once it holds
         always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               cnt_q <= 11'h000;
               deb_q[gi] <= vdc_pkg::IN_IDLE[gi];
            end else if (sync2_q[gi] == deb_q[gi]) begin
               cnt_q <= 11'h000;
            end else if (cnt_q == vdc_pkg::DEB_LAST) begin
               cnt_q <= 11'h000;
               deb_q[gi] <= sync2_q[gi];
            end else begin
               cnt_q <= cnt_q + 11'h001;
            end
         end
      end
   endgenerate

   assign pwr = !deb_q[vdc_pkg::IN_POWER];
   assign ptt = !deb_q[vdc_pkg::IN_PTT];
   assign permit = !deb_q[vdc_pkg::IN_PERMIT];
   assign setup_en = !deb_q[vdc_pkg::IN_SETUP];
   assign emergency_request_act = EMERGENCY_REQUEST_VARIANT && pwr &&
                      !deb_q[vdc_pkg::IN_EMERGENCY_REQUEST];
   assign overtemp = deb_q[vdc_pkg::IN_OVERTEMP];
   assign vswr = deb_q[vdc_pkg::IN_VSWR];

   // Stuck-key timer runs only while the key is held and keyed
   assign stuck_hit = tx_q && (stuck_cnt_q == STUCK_CYCLES - 32'd1);

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         stuck_cnt_q <= 32'h0000_0000;
      end else if (tx_q && !stuck_hit) begin
         stuck_cnt_q <= stuck_cnt_q + 32'd1;
      end else begin
         stuck_cnt_q <= 32'h0000_0000;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         stuck_q <= 1'b0;
      end else if (stuck_hit) begin
         stuck_q <= 1'b1;
      end else if (!ptt) begin
         stuck_q <= 1'b0;
      end
   end

   // Overheat holds the transmitter off as well
   assign tx_d = pwr && ptt && permit && !stuck_q && !stuck_hit &&
                 !overtemp;

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tx_q <= 1'b0;
      end else begin
         tx_q <= tx_d;
      end
   end

   // Register writes
   assign band_high = EXT_BAND ? vdc_pkg::BAND_EXT_KHZ
                               : vdc_pkg::BAND_HIGH_KHZ;
   assign freq_ok = (WDATA_I[17:0] >= vdc_pkg::BAND_LOW_KHZ) &&
                    (WDATA_I[17:0] <= band_high);
   assign wr_freq = WR_I && (ADDR_I == vdc_pkg::FREQ_ADDR);

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl_q <= vdc_pkg::CTRL_RESET;
      end else if (WR_I && ADDR_I == vdc_pkg::CTRL_ADDR) begin
         ctrl_q <= WDATA_I[4:0];
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         emergency_request_q <= 1'b0;
      end else begin
         emergency_request_q <= emergency_request_act;
      end
   end

   // Emergency overrides both tuning and the spacing setting
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tune_q.narrow <= 1'b0;
         tune_q.freq_khz <= vdc_pkg::FREQ_RESET;
      end else if (emergency_request_act) begin
         tune_q.narrow <= 1'b0;
         tune_q.freq_khz <= vdc_pkg::EMERGENCY_REQUEST_KHZ;
      end else if (wr_freq && freq_ok) begin
         tune_q.freq_khz <= WDATA_I[17:0];
         tune_q.narrow <= ctrl_q[vdc_pkg::CTRL_NARROW_BIT];
      end
   end

   // Out-of-band or emergency-blocked tuning is flagged; set wins
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         reject_q <= 1'b0;
      end else if (wr_freq && (!freq_ok || emergency_request_act)) begin
         reject_q <= 1'b1;
      end else if (WR_I && ADDR_I == vdc_pkg::STATUS_ADDR &&
                   WDATA_I[vdc_pkg::ST_REJECT_BIT]) begin
         reject_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         stuck_ev_q <= 1'b0;
      end else if (stuck_hit) begin
         stuck_ev_q <= 1'b1;
      end else if (WR_I && ADDR_I == vdc_pkg::STATUS_ADDR &&
                   WDATA_I[vdc_pkg::ST_STUCK_EV_BIT]) begin
         stuck_ev_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         setup_q <= vdc_pkg::SETUP_RESET;
      end else if (WR_I && ADDR_I == vdc_pkg::SETUP_ADDR && setup_en) begin
         setup_q <= WDATA_I[15:0];
      end
   end

   // Register reads, data valid in the following cycle only
   always_comb begin
      status = 32'h0000_0000;
      status[vdc_pkg::ST_TX_BIT] = tx_q;
      status[vdc_pkg::ST_STUCK_BIT] = stuck_q;
      status[vdc_pkg::ST_EMERGENCY_REQUEST_BIT] = emergency_request_q;
      status[vdc_pkg::ST_POWER_BIT] = pwr;
      status[vdc_pkg::ST_STATION_BIT] = !deb_q[vdc_pkg::IN_STATION];
      status[vdc_pkg::ST_RS422_BIT] = !deb_q[vdc_pkg::IN_PORT];
      status[vdc_pkg::ST_DESENSE_BIT] = !deb_q[vdc_pkg::IN_DESENSE];
      status[vdc_pkg::ST_SETUP_BIT] = setup_en;
      status[vdc_pkg::ST_PERMIT_BIT] = permit;
      status[vdc_pkg::ST_OVERTEMP_BIT] = overtemp;
      status[vdc_pkg::ST_VSWR_BIT] = vswr;
      status[vdc_pkg::ST_REJECT_BIT] = reject_q;
      status[vdc_pkg::ST_STUCK_EV_BIT] = stuck_ev_q;
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (RD_I) begin
         unique case (ADDR_I)
            vdc_pkg::CTRL_ADDR: rd_d = {27'h0, ctrl_q};
            vdc_pkg::FREQ_ADDR: rd_d = {13'h0, tune_q};
            vdc_pkg::STATUS_ADDR: rd_d = status;
            vdc_pkg::SETUP_ADDR: rd_d = setup_en ? {16'h0, setup_q}
                                                 : 32'h0;
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         RDATA_O <= 32'h0000_0000;
      end else begin
         RDATA_O <= rd_d;
      end
   end

   // Indicators; VSWR is a warning, heat or failed test a failure
   assign yellow_d = pwr && (ctrl_q[vdc_pkg::CTRL_WARN_BIT] || vswr);
   assign red_d = pwr && (ctrl_q[vdc_pkg::CTRL_FAIL_BIT] || overtemp);
   // Audio reaches the line only in receive with squelch open
   assign audio_d = pwr && !tx_d &&
                    (!ctrl_q[vdc_pkg::CTRL_SQUELCH_BIT] ||
                     deb_q[vdc_pkg::IN_AUDIO]);

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         POWER_EN_O <= 1'b0;
         TX_KEY_O <= 1'b0;
         SIDETONE_O <= 1'b0;
         RX_DESENSE_O <= 1'b0;
         STATION_SECOND_O <= 1'b0;
         USE_RS422_O <= 1'b0;
         TUNE_O <= '0;
         LED_O <= '0;
         FAULT_O <= 1'b0;
         FAULT_OE_O <= 1'b0;
         AUDIO_PRESENT_O <= 1'b0;
         AUDIO_PRESENT_OE_O <= 1'b0;
      end else begin
         POWER_EN_O <= pwr;
         TX_KEY_O <= tx_d;
         SIDETONE_O <= tx_d && ctrl_q[vdc_pkg::CTRL_SIDETONE_BIT];
         RX_DESENSE_O <= pwr && !deb_q[vdc_pkg::IN_DESENSE];
         STATION_SECOND_O <= !deb_q[vdc_pkg::IN_STATION];
         USE_RS422_O <= !deb_q[vdc_pkg::IN_PORT];
         TUNE_O <= tune_q;
         LED_O.green <= pwr && !yellow_d && !red_d;
         LED_O.yellow <= yellow_d;
         LED_O.red <= red_d;
         FAULT_O <= 1'b0;
         FAULT_OE_O <= yellow_d || red_d;
         AUDIO_PRESENT_O <= 1'b0;
         AUDIO_PRESENT_OE_O <= audio_d;
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);

   power_gate_a: assert property (TX_KEY_O |-> POWER_EN_O)
      else $error("Transmitter keyed while unit powered down");
   permit_block_a: assert property (!permit |=> !tx_q)
      else $error("Transmission while permit inactive");
   stuck_stop_a: assert property ($rose(stuck_q) |-> !tx_q ##1 !tx_q)
      else $error("Transmission continued past stuck-key limit");
   stuck_count_a: assert property (tx_q |-> stuck_cnt_q < STUCK_CYCLES)
      else $error("Stuck-key counter overran its limit");
   rearm_hold_a: assert property (stuck_q && ptt |=> stuck_q)
      else $error("Stuck-key lock cleared while key held");
   fault_or_a: assert property (FAULT_OE_O == (LED_O.yellow || LED_O.red))
      else $error("Fault output disagrees with indicators");
   audio_tx_a: assert property (TX_KEY_O |-> !AUDIO_PRESENT_OE_O)
      else $error("Audio indicator active during transmit");
   emergency_request_tune_a: assert property ($rose(emergency_request_q) |->
      tune_q.freq_khz == vdc_pkg::EMERGENCY_REQUEST_KHZ && !tune_q.narrow)
      else $error("Emergency entry did not tune the emergency channel");
   emergency_request_lock_a: assert property (emergency_request_q && emergency_request_act && wr_freq
      |=> $stable(tune_q))
      else $error("Tuning changed during emergency");
   band_limit_a: assert property (
      tune_q.freq_khz >= vdc_pkg::BAND_LOW_KHZ &&
      tune_q.freq_khz <= band_high)
      else $error("Tuned frequency outside band");
   setup_lock_a: assert property (!setup_en |=> $stable(setup_q))
      else $error("Setup data changed without access");
   read_slot_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
      else $error("Read data outside its cycle");
   sidetone_tx_a: assert property (SIDETONE_O |-> TX_KEY_O)
      else $error("Sidetone routed outside transmit");
   desense_pwr_a: assert property (RX_DESENSE_O |-> POWER_EN_O)
      else $error("Receiver desense while unit powered down");
   green_clear_a: assert property (LED_O.green |-> !FAULT_OE_O)
      else $error("Operable indicator lit beside a fault");
   stuck_flag_a: assert property (stuck_hit |=> stuck_ev_q)
      else $error("Stuck-key event not recorded");
   emergency_request_reject_a: assert property (wr_freq && emergency_request_act |=> reject_q)
      else $error("Tuning command in emergency not flagged");

   tx_seen_c: cover property ($rose(TX_KEY_O));
   stuck_seen_c: cover property ($rose(stuck_q));
   emergency_request_seen_c: cover property ($rose(emergency_request_q));
   reject_seen_c: cover property ($rose(reject_q));
   audio_seen_c: cover property ($rose(AUDIO_PRESENT_OE_O));
endmodule : vdc_top
`default_nettype wire

// ---- bench/vdc_partner.sv ----
// Aircraft discrete wiring seen from the transceiver connector
`timescale 1ns/1ps
`default_nettype none
module vdc_partner (
   input wire logic [10:0] want_b_i,
   input wire logic fault_i,
   input wire logic fault_oe_i,
   input wire logic audio_i,
   input wire logic audio_oe_i,
   output logic [10:0] pins_o,
   output logic fault_line_o,
   output logic audio_line_o
);
   // Bit 4 is the desense line, passed straight through like every other pin
   assign pins_o = want_b_i;
   // Open-drain lines pulled up by the relay coil when released
   assign fault_line_o = fault_oe_i ? fault_i : 1'b1;
   assign audio_line_o = audio_oe_i ? audio_i : 1'b1;
endmodule : vdc_partner
`default_nettype wire

// ---- bench/vdc_top_tb.sv ----
// Self-checking bench for the radio discrete control block
`timescale 1ns/1ps
`default_nettype none
module vdc_top_tb;
   localparam int STUCK = 2000;
   localparam int SETTLE = 1300;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [10:0] want_b = vdc_pkg::IN_IDLE;
   logic [10:0] pin;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic pwr, tx, side, des, st2, rs, f_o, f_oe, a_o, a_oe, f_n, a_n;
   vdc_pkg::vdc_tune_type tune;
   vdc_pkg::vdc_led_type led;
   int fail_count = 0;
   int comparisons = 0;
   logic [31:0] r;
   logic [17:0] t_exp;
   // Pins, then {power,tx,desense,second,rs422,fault_n,audio_n,red}
   logic [10:0] row_in [8] = '{11'h0be, 11'h0bc, 11'h4b2, 11'h2be,
      11'h1bc, 11'h0ae, 11'h0fc, 11'h0ff};
   logic [7:0] row_exp [8] = '{8'h86, 8'hc6, 8'h9c, 8'h82, 8'h83, 8'ha6,
      8'h86, 8'h06};
   logic [17:0] f_tab [4] = '{18'h1d8a8, 18'h2170f, 18'h21710, 18'h1ccef};
   logic [3:0] f_ok = 4'b0011;

   always #4 clk = ~clk;

   vdc_partner u_partner (.want_b_i(want_b), .fault_i(f_o),
      .fault_oe_i(f_oe), .audio_i(a_o), .audio_oe_i(a_oe), .pins_o(pin),
      .fault_line_o(f_n), .audio_line_o(a_n));

   vdc_top #(.STUCK_CYCLES(32'(STUCK))) u_dut (.REF_CLK_I(clk),
      .RST_B_I(rst_b), .PWR_REQ_B_I(pin[0]), .PUSH_TO_TALK_B_I(pin[1]),
      .STATION_SELECT_B_I(pin[2]), .SERIAL_PORT_SELECT_B_I(pin[3]),
      .RECEIVER_DESENSE_B_I(pin[4]), .SETUP_ACCESS_ENABLE_B_I(pin[5]),
      .TX_PERMIT_B_I(pin[6]), .EMERGENCY_REQUEST_B_I(pin[7]),
      .OVERTEMP_I(pin[8]), .VSWR_HIGH_I(pin[9]), .RX_AUDIO_I(pin[10]),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .POWER_EN_O(pwr), .TX_KEY_O(tx),
      .SIDETONE_O(side), .RX_DESENSE_O(des), .STATION_SECOND_O(st2),
      .USE_RS422_O(rs), .TUNE_O(tune), .LED_O(led), .FAULT_O(f_o),
      .FAULT_OE_O(f_oe), .AUDIO_PRESENT_O(a_o),
      .AUDIO_PRESENT_OE_O(a_oe));

   task automatic chk(input string what, input logic [31:0] got,
      input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data only stands in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      r = rdata;
   endtask : rd_reg

   // Holds longer than the input filter so the new level is accepted
   task automatic pins(input logic [10:0] v);
      @(posedge clk);
      want_b <= v;
      repeat (SETTLE) @(posedge clk);
      #1;
   endtask : pins

   task automatic close_out();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         pins(row_in[i]);
         chk("discretes", {pwr, tx, des, st2, rs, f_n, a_n, led.red},
            row_exp[i]);
      end
      wr_reg(vdc_pkg::CTRL_ADDR, 32'h0000_0006);
      pins(11'h0bc);
      chk("tx", tx, 1'b1);
      chk("sidetone", side, 1'b1);
      repeat (STUCK) @(posedge clk);
      #1;
      chk("tx stuck", tx, 1'b0);
      rd_reg(vdc_pkg::STATUS_ADDR);
      chk("stuck lock", r[vdc_pkg::ST_STUCK_BIT], 1'b1);
      chk("stuck event", r[vdc_pkg::ST_STUCK_EV_BIT], 1'b1);
      chk("tx status", r[vdc_pkg::ST_TX_BIT], 1'b0);
      pins(11'h0be);
      pins(11'h0bc);
      chk("tx rearm", tx, 1'b1);
      rd_reg(vdc_pkg::STATUS_ADDR);
      chk("tx status on", r[vdc_pkg::ST_TX_BIT], 1'b1);
      pins(11'h0be);
      // Narrow spacing, then band edges on both sides
      wr_reg(vdc_pkg::CTRL_ADDR, 32'h0000_0005);
      t_exp = vdc_pkg::FREQ_RESET;
      for (int i = 0; i < 4; i++) begin
         wr_reg(vdc_pkg::FREQ_ADDR, {14'h0, f_tab[i]});
         if (f_ok[i]) begin
            t_exp = f_tab[i];
         end
         rd_reg(vdc_pkg::STATUS_ADDR);
         chk("tune", tune, {1'b1, t_exp});
         chk("reject", r[vdc_pkg::ST_REJECT_BIT], !f_ok[i]);
         wr_reg(vdc_pkg::STATUS_ADDR, 32'h0000_0800);
      end
      pins(11'h03e);
      chk("emergency_request tune", tune, {1'b0, vdc_pkg::EMERGENCY_REQUEST_KHZ});
      wr_reg(vdc_pkg::FREQ_ADDR, 32'h0001_d8a8);
      rd_reg(vdc_pkg::STATUS_ADDR);
      chk("emergency_request hold", tune, {1'b0, vdc_pkg::EMERGENCY_REQUEST_KHZ});
      chk("emergency_request status", r[vdc_pkg::ST_EMERGENCY_REQUEST_BIT], 1'b1);
      chk("emergency_request reject", r[vdc_pkg::ST_REJECT_BIT], 1'b1);
      pins(11'h0be);
      wr_reg(vdc_pkg::SETUP_ADDR, 32'h0000_1234);
      rd_reg(vdc_pkg::SETUP_ADDR);
      chk("setup locked", r, 32'h0);
      pins(11'h09e);
      wr_reg(vdc_pkg::SETUP_ADDR, 32'h0000_1234);
      rd_reg(vdc_pkg::SETUP_ADDR);
      chk("setup open", r, 32'h0000_1234);
      // Warning and failure set, squelch off
      wr_reg(vdc_pkg::CTRL_ADDR, 32'h0000_0018);
      @(posedge clk);
      #1;
      chk("leds fault", led, 3'b011);
      chk("fault line", f_n, 1'b0);
      chk("audio squelch off", a_n, 1'b0);
      wr_reg(vdc_pkg::CTRL_ADDR, 32'h0000_0004);
      @(posedge clk);
      #1;
      chk("leds ok", led, 3'b100);
      chk("fault clear", f_n, 1'b1);
      chk("audio muted", a_n, 1'b1);
      rd_reg(8'h10);
      chk("unmapped", r, 32'h0);
      // Second reset in mid-run
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("reset power", pwr, 1'b0);
      chk("reset tune", tune, 32'h0);
      @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      chk("tune after reset", tune, {1'b0, vdc_pkg::FREQ_RESET});
      close_out();
   end
endmodule : vdc_top_tb
`default_nettype wire
